/* nirm_ee_loader.v */
// Serial EEPROM reader that shifts in the 64-bit node identifier.
// Assumes a simple clocked serial part: one bit sampled per divided clock.
`timescale 1ns/10ps
`default_nettype none
`include "nirm_map.vh"

module nirm_ee_loader #(
  parameter BIT_CYC = `NIRM_EE_BIT_CYC,
  parameter NBITS = 64
) (
  input wire mclk_i,
  input wire resetn_i,
  input wire start_i,
  input wire ee_data_i,
  output reg ee_clk_o,
  output reg ee_sel_o,
  output reg [NBITS-1:0] word_o,
  output reg done_o
);

  reg [15:0] div_r;
  reg [6:0] cnt_r;
  reg busy_r;

  // One bit per bit time: clock high in the second half, sample at the end.
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div_r <= 16'h0000;
      cnt_r <= 7'h00;
      busy_r <= 1'b0;
      ee_clk_o <= 1'b0;
      ee_sel_o <= 1'b0;
      word_o <= {NBITS{1'b0}};
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i && !busy_r)
      begin
        busy_r <= 1'b1;
        ee_sel_o <= 1'b1;
        div_r <= 16'h0000;
        cnt_r <= 7'h00;
      end
      else if (busy_r)
      begin
        ee_clk_o <= (div_r >= BIT_CYC / 2);
        if (div_r == BIT_CYC - 1)
        begin
          div_r <= 16'h0000;
          word_o <= {word_o[NBITS-2:0], ee_data_i};
          cnt_r <= cnt_r + 7'h01;
          if (cnt_r == NBITS - 1)
          begin
            busy_r <= 1'b0;
            ee_sel_o <= 1'b0;
            ee_clk_o <= 1'b0;
            done_o <= 1'b1;
          end
        end
        else
          div_r <= div_r + 16'h0001;
      end
    end
  end

endmodule // nirm_ee_loader
`default_nettype wire

/* nirm_ee_model.sv */
// Serial identifier memory model on the far side of the loader.
// Assumes one bit per loader clock, MSB first, advanced on falling clock.
`timescale 1ns/10ps
`default_nettype none
module nirm_ee_model #(
  parameter logic [63:0] UID = 64'h0
) (
  input wire logic ee_clk_i,
  input wire logic ee_sel_i,
  output logic ee_data_o
);
  logic [5:0] n;
  // Present the top bit when selected.
  always @(posedge ee_sel_i)
  begin
    n = 6'h0;
    ee_data_o = UID[63];
  end
  // Next bit after each clock while selected.
  always @(negedge ee_clk_i)
    if (ee_sel_i)
    begin
      n = n + 6'h1;
      ee_data_o = UID[~n];
    end
  // Deselect inverts the data once, so the last bit is not left standing as it was.
  always @(negedge ee_sel_i) ee_data_o = ~ee_data_o;
endmodule // nirm_ee_model
`default_nettype wire

/* nirm_map.vh */
// Register offsets, field positions, reset values and timing counts for the
// node identifier, configuration ROM mapping and posted write capture block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef NIRM_MAP_VH
`define NIRM_MAP_VH

// Byte offsets of the registers on the plain register port.
`define NIRM_OFS_UID_UPPER 8'h24
`define NIRM_OFS_UID_LOWER 8'h28
`define NIRM_OFS_ROM_BASE 8'h34
`define NIRM_OFS_FAIL_LOW 8'h38
`define NIRM_OFS_FAIL_HIGH 8'h3c
`define NIRM_OFS_IRQ_STATUS 8'h60
`define NIRM_OFS_IRQ_CLEAR 8'h64
`define NIRM_OFS_IRQ_ENABLE 8'h68
`define NIRM_OFS_LOAD_STATUS 8'h6c

// Reset values.
`define NIRM_RST_UID 32'h0000_0000
`define NIRM_RST_ROM_BASE 32'h0000_0000
`define NIRM_RST_CAPTURE 32'h0000_0000

// Field positions.
`define NIRM_ROM_BASE_LSB 10
`define NIRM_ROM_OFS_BITS 10
`define NIRM_SRC_LSB 16
`define NIRM_IRQ_BITS 2
`define NIRM_IRQ_FAIL 0
`define NIRM_IRQ_LOADED 1

// Configuration ROM window in the 48-bit 1394 offset space.
`define NIRM_ROM_WIN_LO 48'hFFFF_F000_0400
`define NIRM_ROM_WIN_HI 48'hFFFF_F000_07FF

// Serial EEPROM bit time in nanoseconds and the clock period.
`define NIRM_EE_BIT_NS 10000
`define NIRM_CLK_NS 40
`define NIRM_EE_BIT_CYC ((`NIRM_EE_BIT_NS + `NIRM_CLK_NS - 1) / `NIRM_CLK_NS)

`endif

/* nirm_regs.v */
// Top register bank of the node identifier block.
// Assumes a plain register port with one-cycle strobes and read data one
// cycle after the read strobe; all inputs synchronous to mclk_i.
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "nirm_map.vh"

module nirm_regs #(
  parameter EE_BIT_CYC = `NIRM_EE_BIT_CYC
) (
  input wire mclk_i,
  input wire resetn_i,
  input wire bus_resetn_i,
  input wire ee_present_i,
  input wire ee_data_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire rom_req_i,
  input wire [47:0] rom_offset_i,
  input wire post_fail_i,
  input wire [15:0] post_src_i,
  input wire [47:0] post_offset_i,
  output reg [31:0] rdata_o,
  output reg ee_clk_o,
  output reg ee_sel_o,
  output reg rom_hit_o,
  output reg rom_miss_o,
  output reg [31:0] rom_addr_o,
  output reg irq_o
);

  reg [31:0] uid_upper_r;
  reg [31:0] uid_lower_r;
  reg [31:0] rom_base_r;
  reg [31:0] fail_low_r;
  reg [31:0] fail_high_r;
  reg [`NIRM_IRQ_BITS-1:0] irq_stat_r;
  reg [`NIRM_IRQ_BITS-1:0] irq_en_r;
  reg [`NIRM_IRQ_BITS-1:0] irq_stat_nxt;
  reg bus_rst_d_r;
  reg load_req_r;
  reg loaded_r;
  reg [31:0] rdata_nxt;
  wire [63:0] ee_word;
  wire ee_done;
  wire ee_clk;
  wire ee_sel;
  wire x_hit;
  wire x_miss;
  wire [31:0] x_addr;

  // Address decode for the write paths; the read mux decodes with its own case.
  function is_at;
    input [7:0] a;
    input [7:0] ofs;
    begin
      is_at = (a == ofs);
    end
  endfunction

  nirm_ee_loader #(
    .BIT_CYC(EE_BIT_CYC),
    .NBITS(64)
  ) u_loader (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .start_i(load_req_r),
    .ee_data_i(ee_data_i),
    .ee_clk_o(ee_clk),
    .ee_sel_o(ee_sel),
    .word_o(ee_word),
    .done_o(ee_done)
  );

  nirm_rom_xlate u_xlate (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .req_i(rom_req_i),
    .offset_i(rom_offset_i),
    .base_i(rom_base_r),
    .hit_o(x_hit),
    .miss_o(x_miss),
    .addr_o(x_addr)
  );

  // A load starts on the release of the bus reset, only with an EEPROM.
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bus_rst_d_r <= 1'b0;
      load_req_r <= 1'b0;
    end
    else
    begin
      bus_rst_d_r <= bus_resetn_i;
      load_req_r <= bus_resetn_i && !bus_rst_d_r && ee_present_i;
    end
  end

  // Identifier quadlets: zero on hardware reset, software cannot write.
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      uid_upper_r <= `NIRM_RST_UID;
      uid_lower_r <= `NIRM_RST_UID;
      loaded_r <= 1'b0;
    end
    else if (ee_done)
    begin
      uid_upper_r <= ee_word[63:32];
      uid_lower_r <= ee_word[31:0];
      loaded_r <= 1'b1;
    end
  end

  // ROM base: low ten bits are held at zero so writes there are lost.
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rom_base_r <= `NIRM_RST_ROM_BASE;
    else if (wr_i && is_at(addr_i, `NIRM_OFS_ROM_BASE))
      rom_base_r <= {wdata_i[31:`NIRM_ROM_BASE_LSB],
        {`NIRM_ROM_BASE_LSB{1'b0}}};
  end

  // Both capture words load in the same cycle as the failure strobe.
  // Reset is documented as undefined; zero is given for clean simulation.
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      fail_low_r <= `NIRM_RST_CAPTURE;
      fail_high_r <= `NIRM_RST_CAPTURE;
    end
    else if (post_fail_i)
    begin
      fail_low_r <= post_offset_i[31:0];
      fail_high_r <= {post_src_i, post_offset_i[47:32]};
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle.
  always @*
  begin
    irq_stat_nxt = irq_stat_r;
    if (wr_i && is_at(addr_i, `NIRM_OFS_IRQ_CLEAR))
      irq_stat_nxt = irq_stat_nxt & ~wdata_i[`NIRM_IRQ_BITS-1:0];
    if (post_fail_i)
      irq_stat_nxt[`NIRM_IRQ_FAIL] = 1'b1;
    if (ee_done)
      irq_stat_nxt[`NIRM_IRQ_LOADED] = 1'b1;
  end

  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      irq_stat_r <= {`NIRM_IRQ_BITS{1'b0}};
      irq_en_r <= {`NIRM_IRQ_BITS{1'b0}};
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_i && is_at(addr_i, `NIRM_OFS_IRQ_ENABLE))
        irq_en_r <= wdata_i[`NIRM_IRQ_BITS-1:0];
    end
  end

  // Read mux; unmapped and write-only offsets read as zero.
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    case (addr_i)
      `NIRM_OFS_UID_UPPER: rdata_nxt = uid_upper_r;
      `NIRM_OFS_UID_LOWER: rdata_nxt = uid_lower_r;
      `NIRM_OFS_ROM_BASE: rdata_nxt = {rom_base_r[31:`NIRM_ROM_BASE_LSB],
        {`NIRM_ROM_BASE_LSB{1'b0}}};
      `NIRM_OFS_FAIL_LOW: rdata_nxt = fail_low_r;
      `NIRM_OFS_FAIL_HIGH: rdata_nxt = fail_high_r;
      `NIRM_OFS_IRQ_STATUS: rdata_nxt = {30'h0000_0000, irq_stat_r};
      `NIRM_OFS_IRQ_ENABLE: rdata_nxt = {30'h0000_0000, irq_en_r};
      `NIRM_OFS_LOAD_STATUS: rdata_nxt = {31'h0000_0000, loaded_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Outputs are registered; read data stands only in the cycle after rd_i.
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_o <= 32'h0000_0000;
      ee_clk_o <= 1'b0;
      ee_sel_o <= 1'b0;
      rom_hit_o <= 1'b0;
      rom_miss_o <= 1'b0;
      rom_addr_o <= 32'h0000_0000;
      irq_o <= 1'b0;
    end
    else
    begin
      rdata_o <= rd_i ? rdata_nxt : 32'h0000_0000;
      ee_clk_o <= ee_clk;
      ee_sel_o <= ee_sel;
      rom_hit_o <= x_hit;
      rom_miss_o <= x_miss;
      rom_addr_o <= x_addr;
      irq_o <= |(irq_stat_nxt & irq_en_r);
    end
  end

endmodule // nirm_regs
`default_nettype wire

/* nirm_regs_props.sv */
// Checker for the node identifier register bank.
// Sees only the ports of nirm_regs and is bound to it below.
`timescale 1ns/10ps
`default_nettype none
module nirm_regs_props #(
  parameter EE_BIT_CYC = 4
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic rom_req_i,
  input wire logic [47:0] rom_offset_i,
  input wire logic post_fail_i,
  input wire logic [15:0] post_src_i,
  input wire logic [47:0] post_offset_i,
  input wire logic [31:0] rdata_o,
  input wire logic rom_hit_o,
  input wire logic rom_miss_o,
  input wire logic [31:0] rom_addr_o,
  input wire logic irq_o
);
  logic [31:0] base_r;
  logic [31:0] lo_r;
  logic [31:0] hi_r;
  logic en_r;
  logic in_win;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // A request inside the ROM window.
  assign in_win = rom_offset_i >= 48'hFFFF_F000_0400 &&
    rom_offset_i <= 48'hFFFF_F000_07FF;
  // Shadows of what software wrote and what the last failure left.
  always_ff @(posedge mclk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      base_r <= 32'h0000_0000;
      lo_r <= 32'h0000_0000;
      hi_r <= 32'h0000_0000;
      en_r <= 1'b0;
    end
    else
    begin
      if (wr_i && addr_i == 8'h34) base_r <= wdata_i & 32'hFFFF_FC00;
      if (wr_i && addr_i == 8'h68) en_r <= wdata_i[0];
      if (post_fail_i) lo_r <= post_offset_i[31:0];
      if (post_fail_i) hi_r <= {post_src_i, post_offset_i[47:32]};
    end
  property p_rom_rd;
    $past(rd_i) && $past(addr_i) == 8'h34 |-> rdata_o == base_r;
  endproperty
  a_rom_rd: assert property (p_rom_rd) else $error("rom base bad");
  property p_rom_lsb;
    $past(rd_i) && $past(addr_i) == 8'h34 |-> rdata_o[9:0] == 10'h000;
  endproperty
  a_rom_lsb: assert property (p_rom_lsb) else $error("low bits set");
  property p_hit;
    rom_req_i && in_win |-> ##2 rom_hit_o &&
      rom_addr_o == base_r + {22'h0, $past(rom_offset_i[9:0], 2)};
  endproperty
  a_hit: assert property (p_hit) else $error("rom hit bad");
  property p_miss;
    rom_req_i && !in_win |-> ##2 rom_miss_o && !rom_hit_o;
  endproperty
  a_miss: assert property (p_miss) else $error("rom miss bad");
  property p_quiet;
    !$past(rom_req_i, 2) |-> !rom_hit_o && !rom_miss_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray answer");
  property p_cap_lo;
    $past(rd_i) && $past(addr_i) == 8'h38 |-> rdata_o == lo_r;
  endproperty
  a_cap_lo: assert property (p_cap_lo) else $error("low cap bad");
  property p_cap_hi;
    $past(rd_i) && $past(addr_i) == 8'h3c |-> rdata_o == hi_r;
  endproperty
  a_cap_hi: assert property (p_cap_hi) else $error("high cap bad");
  property p_irq;
    post_fail_i && en_r |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  c_hit: cover property (rom_hit_o);
  c_miss: cover property (rom_miss_o);
  c_irq: cover property ($rose(irq_o));
endmodule // nirm_regs_props
bind nirm_regs nirm_regs_props #(.EE_BIT_CYC(EE_BIT_CYC)) u_props (.*);
`default_nettype wire

/* nirm_rom_xlate.v */
// Translates a configuration ROM quadlet read offset to a host address.
// Assumes the request strobe is one cycle long and synchronous to mclk_i.
`timescale 1ns/10ps
`default_nettype none
`include "nirm_map.vh"

module nirm_rom_xlate (
  input wire mclk_i,
  input wire resetn_i,
  input wire req_i,
  input wire [47:0] offset_i,
  input wire [31:0] base_i,
  output reg hit_o,
  output reg miss_o,
  output reg [31:0] addr_o
);

  wire in_win;

  // Only offsets inside the ROM window are redirected to host memory.
  assign in_win = (offset_i >= `NIRM_ROM_WIN_LO) &&
    (offset_i <= `NIRM_ROM_WIN_HI);

  // The base is 1 KB aligned, so adding the ten low bits never carries.
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      hit_o <= 1'b0;
      miss_o <= 1'b0;
      addr_o <= 32'h0000_0000;
    end
    else
    begin
      hit_o <= req_i && in_win;
      miss_o <= req_i && !in_win;
      if (req_i && in_win)
        addr_o <= base_i + {22'h00_0000, offset_i[9:0]};
    end
  end

endmodule // nirm_rom_xlate
`default_nettype wire

/* node_id_rom_map_posted_error_regs_bench.sv */
// Self-checking bench for the node identifier register bank.
// Drives nirm_regs directly; the serial memory model sits beside it.
`timescale 1ns/10ps
`default_nettype none
module node_id_rom_map_posted_error_regs_bench;
  localparam logic [63:0] UID = 64'hA5C3_0F1E_5A69_9612;
  logic mclk_i = 0, resetn_i = 0, bus_resetn_i = 0, ee_present_i = 1;
  logic wr_i = 0, rd_i = 0, rom_req_i = 0, post_fail_i = 0;
  logic [7:0] addr_i = 0;
  logic [31:0] wdata_i = 0, got;
  logic [47:0] rom_offset_i = 0, post_offset_i = 0;
  logic [15:0] post_src_i = 0;
  wire ee_data_i, ee_clk_o, ee_sel_o, rom_hit_o, rom_miss_o, irq_o;
  wire [31:0] rdata_o, rom_addr_o;
  int error_cnt = 0, check_count = 0, cyc = 0;
  nirm_regs #(.EE_BIT_CYC(4)) DUT (.*);
  nirm_ee_model #(.UID(UID)) u_ee (.ee_clk_i(ee_clk_o),
    .ee_sel_i(ee_sel_o), .ee_data_o(ee_data_i));
  // Free running clock.
  always #20 mclk_i = ~mclk_i;
  // Cut a hang short.
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      wrap_up;
    end
  end
  task wrap_up;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge mclk_i);
    wr_i <= 0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task rd(input logic [7:0] a);
    @(posedge mclk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge mclk_i);
    rd_i <= 0;
    @(negedge mclk_i);
    got = rdata_o;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(got, e);
  endtask
  task rq(input logic [47:0] o, input logic h, input logic [31:0] ea);
    @(posedge mclk_i);
    {rom_req_i, rom_offset_i} <= {1'b1, o};
    @(posedge mclk_i);
    rom_req_i <= 0;
    @(posedge mclk_i);
    @(negedge mclk_i);
    chk({30'h0, rom_hit_o, rom_miss_o}, {30'h0, h, !h});
    if (h) chk(rom_addr_o, ea);
  endtask
  task pf(input logic [15:0] s, input logic [47:0] o);
    @(posedge mclk_i);
    {post_fail_i, post_src_i, post_offset_i} <= {1'b1, s, o};
    @(posedge mclk_i);
    post_fail_i <= 0;
    @(negedge mclk_i);
  endtask
  task t_reset;
    rdc(8'h24, 0);
    rdc(8'h28, 0);
    rdc(8'h34, 0);
  endtask
  task t_rom;
    wr(8'h34, 32'hFFFF_FFFF);
    rdc(8'h34, 32'hFFFF_FC00);
    wr(8'h34, 32'h1234_5400);
    rq(48'hFFFF_F000_0400, 1, 32'h1234_5400);
    rq(48'hFFFF_F000_07FF, 1, 32'h1234_57FF);
    rq(48'hFFFF_F000_03FF, 0, 0);
    rq(48'hFFFF_F000_0800, 0, 0);
    wr(8'h24, 5);
    rdc(8'h24, 0);
  endtask
  task t_fail;
    wr(8'h68, 1);
    pf(16'hABCD, 48'h1357_2468_ACE0);
    chk({31'h0, irq_o}, 1);
    rdc(8'h38, 32'h2468_ACE0);
    rdc(8'h3c, 32'hABCD_1357);
    wr(8'h3c, 0);
    rdc(8'h3c, 32'hABCD_1357);
    rdc(8'h60, 1);
    wr(8'h64, 1);
    rdc(8'h60, 0);
    chk({31'h0, irq_o}, 0);
    wr(8'h68, 0);
    pf(16'h0001, 48'h4);
    chk({31'h0, irq_o}, 0);
    rdc(8'h38, 4);
    wr(8'h64, 1);
  endtask
  task t_load;
    // A bus reset release with no memory fitted must not start a load.
    @(posedge mclk_i);
    {bus_resetn_i, ee_present_i} <= 2'b10;
    repeat (8) @(posedge mclk_i);
    rdc(8'h6c, 0);
    @(posedge mclk_i);
    {bus_resetn_i, ee_present_i} <= 2'b01;
    repeat (2) @(posedge mclk_i);
    bus_resetn_i <= 1;
    got = 0;
    for (int i = 0; i < 300 && got[0] !== 1'b1; i++) rd(8'h6c);
    rdc(8'h24, UID[63:32]);
    rdc(8'h28, UID[31:0]);
    rd(8'h60);
    chk(got & 2, 2);
  endtask
  // Reset, then each scenario in turn.
  initial
  begin
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1;
    t_reset;
    t_rom;
    t_fail;
    t_load;
    wrap_up;
  end
endmodule // node_id_rom_map_posted_error_regs_bench
`default_nettype wire
